// file: common/ssm_pkg.sv
package ssm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Power-up muting and output sequencing.

    // Output cycles counted while muted, the last count value before release.
    localparam logic [6:0] MUTE_LAST     = 7'h3F;
    // Master ticks come every second reference cycle, so outputs run at a quarter.
    localparam logic       PHASE_LAST    = 1'h1;

    // Sequencer states, one-hot.
    typedef enum logic [1:0]
    {
        ST_MUTED = 2'h1,
        ST_RUN   = 2'h2
    } ssm_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Pseudorandom sequence and modulation code.

    localparam int          LFSR_W   = 15;
    localparam int          CODE_W   = 7;
    localparam logic [14:0] LFSR_SEED = 15'h0001;
    // Feedback taps for a maximal-length 15-bit register.
    localparam int          TAP_HI   = 14;
    localparam int          TAP_LO   = 13;
    // Midscale code that holds the oscillator at its centre frequency.
    localparam logic [6:0]  CODE_MID = 7'h40;

    ////////////////////////////////////////////////////////////////////////////////
    // Rate divider, last count value for each setting.

    localparam logic [5:0] DIV_LAST_16 = 6'h0F;
    localparam logic [5:0] DIV_LAST_32 = 6'h1F;
    localparam logic [5:0] DIV_LAST_64 = 6'h3F;

    // Decoded three-state level of the rate-select pin.
    typedef struct packed
    {
        logic low;
        logic mid;
        logic high;
    } ssm_rate_t;

    localparam ssm_rate_t RATE_RST = '{low: 1'b0, mid: 1'b1, high: 1'b0};

    // Toggle detector: window in output cycles and accepted edge counts.
    localparam logic [5:0] AC_WIN_LAST = 6'h3F;
    localparam logic [7:0] AC_MIN      = 8'h60;
    localparam logic [7:0] AC_MAX      = 8'hA0;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map.

    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  ADDR_STATUS = 4'h4;
    localparam logic [3:0]  ADDR_LFSR   = 4'h8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Control field positions.
    localparam int CTRL_QUAD_BIT = 0;
    localparam int CTRL_OFF_BIT  = 1;
    // Status field positions.
    localparam int STAT_MUTED_BIT  = 0;
    localparam int STAT_ACTIVE_BIT = 1;
    localparam int STAT_AC_BIT     = 2;
    localparam int STAT_RATE_LSB   = 4;
    localparam int STAT_CODE_LSB   = 8;

    // Last count of the rate divider for a decoded rate-select level.
    function automatic logic [5:0] ssm_div_last(input ssm_rate_t r);
        logic [5:0] v;
        v = DIV_LAST_32;
        if (r.low)
        begin
            v = DIV_LAST_16;
        end
        else if (r.high)
        begin
            v = DIV_LAST_64;
        end
        return v;
    endfunction

endpackage

// file: logic/ssm_core.sv
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module ssm_core
(
    // Clock and reset.
    input  wire logic                         ref_clk_in,
    input  wire logic                         arst_n_in,
    // Rate-select pin comparators.
    input  wire logic                         rate_pin_low_in,
    input  wire logic                         rate_pin_high_in,
    // Output clocks and modulation.
    output logic                              clock_out_a_out,
    output logic                              clock_out_b_out,
    output logic [ssm_pkg::CODE_W-1:0]        modulation_dac_out,
    output logic                              spread_active_out,
    // AXI4-Lite write address and data.
    input  wire logic                         s_axi_awvalid_in,
    output logic                              s_axi_awready_out,
    input  wire logic [ssm_pkg::ADDR_W-1:0]   s_axi_awaddr_in,
    input  wire logic                         s_axi_wvalid_in,
    output logic                              s_axi_wready_out,
    input  wire logic [31:0]                  s_axi_wdata_in,
    input  wire logic [3:0]                   s_axi_wstrb_in,
    // AXI4-Lite write response.
    output logic                              s_axi_bvalid_out,
    input  wire logic                         s_axi_bready_in,
    output logic [1:0]                        s_axi_bresp_out,
    // AXI4-Lite read.
    input  wire logic                         s_axi_arvalid_in,
    output logic                              s_axi_arready_out,
    input  wire logic [ssm_pkg::ADDR_W-1:0]   s_axi_araddr_in,
    output logic                              s_axi_rvalid_out,
    input  wire logic                         s_axi_rready_in,
    output logic [31:0]                       s_axi_rdata_out,
    output logic [1:0]                        s_axi_rresp_out
);

    // All state of the core.
    typedef struct packed
    {
        ssm_pkg::ssm_state_t state;     // Muted or running.
        logic                phase;     // Master tick divider.
        logic                int_a;     // Internal first clock, runs while muted.
        logic                out_a;     // Gated first output.
        logic                out_b;     // Gated second output.
        logic [6:0]          mute_cnt;  // Output cycles seen while muted.
        logic [5:0]          div_cnt;   // Rate divider count.
        logic [6:0]          code;      // Modulation code.
        logic                active;    // Modulation running.
        logic                quad;      // Variant select, 1 gives quadrature.
        logic                spread_off;// Software disable of modulation.
        logic                awready;
        logic                wready;
        logic                aw_full;
        logic                w_full;
        logic [3:0]          awaddr;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } ssm_core_st_t;

    localparam ssm_core_st_t CORE_RST = '{
        state:   ssm_pkg::ST_MUTED,
        code:    ssm_pkg::CODE_MID,
        awready: 1'b1,
        wready:  1'b1,
        arready: 1'b1,
        default: '0
    };

    ssm_core_st_t       st_q;        // Registered state.
    ssm_core_st_t       st_d;        // Next state.
    logic [14:0]        lfsr;        // Shift register contents.
    ssm_pkg::ssm_rate_t rate;        // Latched rate-select level.
    logic               ac_det;      // Clock seen on the rate pin.
    logic               tick;        // Master oscillator edge.
    logic               cycle_evt;   // Rising edge of the internal first clock.
    logic               shift_en;    // Shift register clock.
    logic               mute_done;   // Last muted cycle.
    logic [31:0]        status_word; // Status read value.

    ////////////////////////////////////////////////////////////////////////////////
    // Shared event terms.
    always_comb
    begin
        tick      = st_q.phase == ssm_pkg::PHASE_LAST;
        cycle_evt = tick && !st_q.int_a;
        mute_done = cycle_evt && (st_q.state == ssm_pkg::ST_MUTED) &&
                    (st_q.mute_cnt == ssm_pkg::MUTE_LAST);
        shift_en  = cycle_evt && (st_q.state == ssm_pkg::ST_RUN) &&
                    (st_q.div_cnt == ssm_pkg::ssm_div_last(rate));
    end

    // Status word, reserved bits zero.
    always_comb
    begin
        status_word = '0;
        status_word[ssm_pkg::STAT_MUTED_BIT]  = st_q.state == ssm_pkg::ST_MUTED;
        status_word[ssm_pkg::STAT_ACTIVE_BIT] = st_q.active;
        status_word[ssm_pkg::STAT_AC_BIT]     = ac_det;
        status_word[ssm_pkg::STAT_RATE_LSB +: 3] = rate;
        status_word[ssm_pkg::STAT_CODE_LSB +: ssm_pkg::CODE_W] = st_q.code;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Submodules.

    // Pseudorandom sequence source.
    ssm_lfsr u_lfsr
    (
        .ref_clk_in  (ref_clk_in),
        .arst_n_in   (arst_n_in),
        .shift_en_in (shift_en),
        .lfsr_out    (lfsr)
    );

    // Rate-select decode and toggle detector, which is how feedback disables spreading.
    ssm_rate_decode u_dec
    (
        .ref_clk_in    (ref_clk_in),
        .arst_n_in     (arst_n_in),
        .pin_low_in    (rate_pin_low_in),
        .pin_high_in   (rate_pin_high_in),
        .latch_en_in   (shift_en || mute_done),
        .cycle_tick_in (cycle_evt),
        .rate_out      (rate),
        .ac_det_out    (ac_det)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock generation, muting and modulation.
    always_comb
    begin
        st_d       = st_q;
        st_d.phase = ~st_q.phase;
        // Internal clock toggles on each master tick: half rate, equal halves.
        if (tick)
        begin
            st_d.int_a = ~st_q.int_a;
        end
        unique case (st_q.state)
            ssm_pkg::ST_MUTED:
            begin
                // Outputs stay low; the first output rises at release with a full half.
                st_d.out_a = mute_done;
                st_d.out_b = 1'b0;
                if (cycle_evt)
                begin
                    st_d.mute_cnt = st_q.mute_cnt + 7'h01;
                end
                if (mute_done)
                begin
                    st_d.state   = ssm_pkg::ST_RUN;
                    st_d.div_cnt = '0;
                end
            end
            ssm_pkg::ST_RUN:
            begin
                st_d.out_a = st_d.int_a;
                if (st_q.quad)
                begin
                    // One reference cycle late is a quarter output period.
                    st_d.out_b = st_q.int_a;
                end
                else
                begin
                    st_d.out_b = ~st_d.int_a;
                end
                if (cycle_evt)
                begin
                    st_d.div_cnt = shift_en ? 6'h00 : st_q.div_cnt + 6'h01;
                end
            end
        endcase
        // Modulation runs only when released, not disabled and no clock on the pin.
        st_d.active = (st_q.state == ssm_pkg::ST_RUN) && !ac_det && !st_q.spread_off;
        if (!st_d.active)
        begin
            st_d.code = ssm_pkg::CODE_MID;
        end
        else if (shift_en)
        begin
            // Full code range 0..127 spans 0.9 to 1.1 of centre; midscale is centre.
            st_d.code = lfsr[ssm_pkg::CODE_W-1:0];
        end

        ////////////////////////////////////////////////////////////////////////////
        // AXI4-Lite slave: address and data taken in either order.
        if (s_axi_awvalid_in && st_q.awready)
        begin
            st_d.awready = 1'b0;
            st_d.aw_full = 1'b1;
            st_d.awaddr  = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && st_q.wready)
        begin
            st_d.wready = 1'b0;
            st_d.w_full = 1'b1;
            st_d.wdata  = s_axi_wdata_in;
            st_d.wstrb  = s_axi_wstrb_in;
        end
        // Perform the write once both halves are held.
        if (st_q.aw_full && st_q.w_full && !st_q.bvalid)
        begin
            st_d.aw_full = 1'b0;
            st_d.w_full  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = ssm_pkg::RESP_OKAY;
            if (st_q.awaddr == ssm_pkg::ADDR_CTRL)
            begin
                if (st_q.wstrb[0])
                begin
                    st_d.quad       = st_q.wdata[ssm_pkg::CTRL_QUAD_BIT];
                    st_d.spread_off = st_q.wdata[ssm_pkg::CTRL_OFF_BIT];
                end
            end
            else if ((st_q.awaddr != ssm_pkg::ADDR_STATUS) &&
                     (st_q.awaddr != ssm_pkg::ADDR_LFSR))
            begin
                // Unmapped addresses answer with an error and change nothing.
                st_d.bresp = ssm_pkg::RESP_SLVERR;
            end
        end
        // Response accepted: reopen both channels.
        if (st_q.bvalid && s_axi_bready_in)
        begin
            st_d.bvalid  = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready  = 1'b1;
        end
        // Read: data is ready the cycle after the address is taken.
        if (s_axi_arvalid_in && st_q.arready)
        begin
            st_d.arready = 1'b0;
            st_d.rvalid  = 1'b1;
            st_d.rresp   = ssm_pkg::RESP_OKAY;
            st_d.rdata   = '0;
            if (s_axi_araddr_in == ssm_pkg::ADDR_CTRL)
            begin
                st_d.rdata[ssm_pkg::CTRL_QUAD_BIT] = st_q.quad;
                st_d.rdata[ssm_pkg::CTRL_OFF_BIT]  = st_q.spread_off;
            end
            else if (s_axi_araddr_in == ssm_pkg::ADDR_STATUS)
            begin
                st_d.rdata = status_word;
            end
            else if (s_axi_araddr_in == ssm_pkg::ADDR_LFSR)
            begin
                st_d.rdata[ssm_pkg::LFSR_W-1:0] = lfsr;
            end
            else
            begin
                st_d.rresp = ssm_pkg::RESP_SLVERR;
            end
        end
        if (st_q.rvalid && s_axi_rready_in)
        begin
            st_d.rvalid  = 1'b0;
            st_d.arready = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register the state; power-up reset is the only reset.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_q <= CORE_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop.
    assign clock_out_a_out    = st_q.out_a;
    assign clock_out_b_out    = st_q.out_b;
    assign modulation_dac_out = st_q.code;
    assign spread_active_out  = st_q.active;
    assign s_axi_awready_out  = st_q.awready;
    assign s_axi_wready_out   = st_q.wready;
    assign s_axi_bvalid_out   = st_q.bvalid;
    assign s_axi_bresp_out    = st_q.bresp;
    assign s_axi_arready_out  = st_q.arready;
    assign s_axi_rvalid_out   = st_q.rvalid;
    assign s_axi_rdata_out    = st_q.rdata;
    assign s_axi_rresp_out    = st_q.rresp;

endmodule

// file: logic/ssm_lfsr.sv
`timescale 1ns/1ps

// Fifteen-bit Fibonacci shift register that advances on each shift enable.
module ssm_lfsr
(
    // Clock and reset.
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    // Control.
    input  wire logic        shift_en_in,
    // Register contents.
    output logic [14:0]      lfsr_out
);

    // All state of this module.
    typedef struct packed
    {
        logic [14:0] sr;
    } ssm_lfsr_st_t;

    ssm_lfsr_st_t st_q;  // Registered state.
    ssm_lfsr_st_t st_d;  // Next state.

    ////////////////////////////////////////////////////////////////////////////////
    // Shift with maximal-length feedback, the period is two to the fifteenth minus one.
    always_comb
    begin
        st_d = st_q;
        if (shift_en_in)
        begin
            st_d.sr = {st_q.sr[13:0],
                       st_q.sr[ssm_pkg::TAP_HI] ^ st_q.sr[ssm_pkg::TAP_LO]};
        end
    end

    // Register the state; the seed is never all zeros so the sequence cannot lock.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_q.sr <= ssm_pkg::LFSR_SEED;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign lfsr_out = st_q.sr;

endmodule

// file: logic/ssm_rate_decode.sv
`timescale 1ns/1ps

// Decodes and latches the rate-select level and watches the pin for a clock.
module ssm_rate_decode
(
    // Clock and reset.
    input  wire logic              ref_clk_in,
    input  wire logic              arst_n_in,
    // Rate-select pin comparators.
    input  wire logic              pin_low_in,
    input  wire logic              pin_high_in,
    // Timing from the core.
    input  wire logic              latch_en_in,
    input  wire logic              cycle_tick_in,
    // Results.
    output ssm_pkg::ssm_rate_t     rate_out,
    output logic                   ac_det_out
);

    // All state of this module.
    typedef struct packed
    {
        ssm_pkg::ssm_rate_t rate;
        logic               prev;
        logic [5:0]         win;
        logic [7:0]         edges;
        logic               ac_det;
    } ssm_dec_st_t;

    localparam ssm_dec_st_t DEC_RST = '{rate: ssm_pkg::RATE_RST, default: '0};

    ssm_dec_st_t st_q;  // Registered state.
    ssm_dec_st_t st_d;  // Next state.

    ////////////////////////////////////////////////////////////////////////////////
    // Latch the level only at divider boundaries so N never changes mid-count.
    always_comb
    begin
        st_d      = st_q;
        st_d.prev = pin_high_in;
        if (latch_en_in)
        begin
            st_d.rate.low  = pin_low_in && !pin_high_in;
            st_d.rate.high = pin_high_in && !pin_low_in;
            st_d.rate.mid  = pin_low_in == pin_high_in;
        end
        // Count pin edges, saturating, over a fixed window of output cycles.
        if ((pin_high_in != st_q.prev) && (st_q.edges != 8'hFF))
        begin
            st_d.edges = st_q.edges + 8'h01;
        end
        if (cycle_tick_in)
        begin
            st_d.win = st_q.win + 6'h01;
            if (st_q.win == ssm_pkg::AC_WIN_LAST)
            begin
                // An output clock gives two edges per cycle; accept a band around it.
                st_d.ac_det = (st_q.edges >= ssm_pkg::AC_MIN) &&
                              (st_q.edges <= ssm_pkg::AC_MAX);
                st_d.edges  = '0;
            end
        end
    end

    // Register the state.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_q <= DEC_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rate_out   = st_q.rate;
    assign ac_det_out = st_q.ac_det;

endmodule

// file: sim/ssm_core_monitor.sv
`timescale 1ns/1ps

// Watches the output clocks, the modulation code and the bus handshakes.
module ssm_core_monitor
(
    // Clock and reset.
    input  wire logic       ref_clk_in,
    input  wire logic       arst_n_in,
    // Output clocks and modulation.
    input  wire logic       clock_out_a_out,
    input  wire logic       clock_out_b_out,
    input  wire logic [6:0] modulation_dac_out,
    input  wire logic       spread_active_out,
    // Register bus handshakes.
    input  wire logic       s_axi_awvalid_in,
    input  wire logic       s_axi_awready_out,
    input  wire logic       s_axi_wvalid_in,
    input  wire logic       s_axi_wready_out,
    input  wire logic       s_axi_bvalid_out,
    input  wire logic       s_axi_bready_in,
    input  wire logic       s_axi_arvalid_in,
    input  wire logic       s_axi_arready_out,
    input  wire logic       s_axi_rvalid_out
);
    default clocking mon_cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic [8:0] since_rst_q; // Reference cycles since reset release, saturating.
    logic [9:0] gap_q;       // Reference cycles since the code last moved.
    logic [6:0] code_prev_q; // Code one cycle earlier.
    logic       armed_q;     // A code step was seen while spreading.
    logic       code_moved;  // Code differs from the cycle before.

    assign code_moved = modulation_dac_out != code_prev_q;

    // Helper counters; the first step after spreading starts is not timed.
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            since_rst_q <= 9'h000;
            gap_q       <= 10'h000;
            code_prev_q <= ssm_pkg::CODE_MID;
            armed_q     <= 1'b0;
        end
        else
        begin
            since_rst_q <= since_rst_q + {8'h00, since_rst_q != 9'h1FF};
            gap_q       <= code_moved ? 10'h000 : gap_q + 10'h001;
            code_prev_q <= modulation_dac_out;
            armed_q     <= spread_active_out && (armed_q || code_moved);
        end
    end

    sequence high_two;
        clock_out_a_out [*2];
    endsequence
    sequence low_two;
        !clock_out_a_out [*2];
    endsequence

    mute_hold_a:
        assert property (since_rst_q < 9'h0FA |-> !clock_out_a_out && !clock_out_b_out)
        else $error("output clock left mute early");
    out_period_a:
        assert property ($rose(clock_out_a_out) |-> high_two ##1 low_two ##1 clock_out_a_out)
        else $error("output clock period or duty wrong");
    phase_pair_a:
        assert property (clock_out_b_out == !clock_out_a_out
                         || clock_out_b_out == $past(clock_out_a_out))
        else $error("second output neither inverted nor lagging");
    code_mid_a:
        assert property (!spread_active_out && !$past(spread_active_out)
                         |-> modulation_dac_out == ssm_pkg::CODE_MID)
        else $error("code not centred while idle");
    code_step_a:
        assert property (code_moved && armed_q && spread_active_out |-> gap_q[5:0] == 6'h3F)
        else $error("code moved off the shift grid");
    write_answer_a:
        assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
                         && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
        else $error("write response late");
    resp_clear_a:
        assert property (s_axi_bvalid_out && s_axi_bready_in
                         |=> !s_axi_bvalid_out && s_axi_awready_out)
        else $error("write response not retired");
    read_answer_a:
        assert property (s_axi_arvalid_in && s_axi_arready_out
                         |=> s_axi_rvalid_out && !s_axi_arready_out)
        else $error("read answer missing");
endmodule

// file: sim/ssm_rate_driver.sv
`timescale 1ns/1ps

// Rate-select pin as seen through the two comparators.
module ssm_rate_driver
(
    // Mode: 0 ground, 1 floating, 2 supply, 3 first output fed back.
    input  wire logic [1:0] mode_in,
    input  wire logic       clock_out_a_in,
    // Comparator levels.
    output logic            pin_low_out,
    output logic            pin_high_out
);
    // A fed-back clock swings rail to rail, so both comparators toggle.
    always_comb
    begin
        pin_low_out  = mode_in == 2'h0 || (mode_in == 2'h3 && !clock_out_a_in);
        pin_high_out = mode_in == 2'h2 || (mode_in == 2'h3 && clock_out_a_in);
    end
endmodule

// file: sim/test_spread_spectrum_clock_modulator.sv
`timescale 1ns/1ps

module test_spread_spectrum_clock_modulator;
    logic        ref_clk_in = 1'b0;           // Reference clock.
    logic        arst_n_in, rate_pin_low_in, rate_pin_high_in;
    logic        clock_out_a_out, clock_out_b_out, spread_active_out;
    logic [6:0]  modulation_dac_out;
    logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
    logic        s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic        s_axi_arready_out, s_axi_rvalid_out;
    logic [3:0]  s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d, old;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, r, mode;
    logic        p; // First output one cycle back.
    int          n_fail = 0, comparisons = 0;

    ssm_core DUT (.*);
    ssm_rate_driver u_pin (.mode_in(mode), .clock_out_a_in(clock_out_a_out),
        .pin_low_out(rate_pin_low_in), .pin_high_out(rate_pin_high_in));

    always #5 ref_clk_in = ~ref_clk_in;

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Write; address and data offered together, bready held high.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        s_axi_awvalid_in <= 1'b1;
        s_axi_awaddr_in  <= a;
        s_axi_wvalid_in  <= 1'b1;
        s_axi_wdata_in   <= v;
        do
        begin
            @(posedge ref_clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (!s_axi_bvalid_out);
        rs = s_axi_bresp_out;
    endtask

    // Read; data taken at the edge that sees rvalid.
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        s_axi_arvalid_in <= 1'b1;
        s_axi_araddr_in  <= a;
        do
        begin
            @(posedge ref_clk_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (!s_axi_rvalid_out);
        v  = s_axi_rdata_out;
        rs = s_axi_rresp_out;
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog, about six times the expected run.
    initial
    begin
        repeat (30000) @(posedge ref_clk_in);
        n_fail++;
        results();
    end

    // Main sequence.
    initial
    begin
        {arst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = 4'h0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 40'h0;
        {s_axi_bready_in, s_axi_rready_in, s_axi_wstrb_in, mode} = 8'hFD;
        repeat (12) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        axi_rd(ssm_pkg::ADDR_STATUS, d, r);
        chk("muted status", d[1:0], 32'h1);
        $display("test mute done");
        // Each pin level in turn; the rate is latched at the next shift.
        for (int i = 0; i < 3; i++)
        begin
            mode <= i[1:0];
            repeat (700) @(posedge ref_clk_in);
            axi_rd(ssm_pkg::ADDR_STATUS, d, r);
            chk("rate flags", d[6:4], 32'(3'b100 >> i));
            chk("spreading", spread_active_out, 32'h1);
        end
        $display("test rate done");
        // Poll the register until it shifts, then check feedback and code.
        axi_rd(ssm_pkg::ADDR_LFSR, old, r);
        do
            axi_rd(ssm_pkg::ADDR_LFSR, d, r);
        while (d === old);
        chk("lfsr step", d, {17'h0, old[13:0], old[14] ^ old[13]});
        chk("code value", modulation_dac_out, old[6:0]);
        $display("test lfsr done");
        mode <= 2'h3;
        repeat (1200) @(posedge ref_clk_in);
        chk("fed back", spread_active_out, 32'h0);
        chk("centre code", modulation_dac_out, 32'h40);
        axi_rd(ssm_pkg::ADDR_STATUS, d, r);
        chk("clock seen", d[2], 32'h1);
        mode <= 2'h0;
        repeat (1200) @(posedge ref_clk_in);
        chk("resumed", spread_active_out, 32'h1);
        $display("test feedback done");
        axi_wr(ssm_pkg::ADDR_CTRL, 32'h2, r);
        repeat (8) @(posedge ref_clk_in);
        chk("forced off", {spread_active_out, modulation_dac_out}, 32'h40);
        axi_rd(ssm_pkg::ADDR_CTRL, d, r);
        chk("ctrl read", d, 32'h2);
        axi_wr(ssm_pkg::ADDR_CTRL, 32'h1, r);
        repeat (8) @(posedge ref_clk_in);
        for (int k = 0; k < 8; k++)
        begin
            p = clock_out_a_out;
            @(posedge ref_clk_in);
            chk("quarter lag", clock_out_b_out, p);
        end
        axi_wr(ssm_pkg::ADDR_CTRL, 32'h0, r);
        repeat (8) @(posedge ref_clk_in);
        repeat (8)
        begin
            @(posedge ref_clk_in);
            chk("inverse", clock_out_b_out, !clock_out_a_out);
        end
        $display("test outputs done");
        axi_rd(4'hC, d, r);
        chk("unmapped read", {r, d[29:0]}, {ssm_pkg::RESP_SLVERR, 30'h0});
        axi_wr(4'hC, 32'h3, r);
        chk("unmapped write", r, ssm_pkg::RESP_SLVERR);
        axi_wr(ssm_pkg::ADDR_STATUS, 32'h3, r);
        chk("status write", r, ssm_pkg::RESP_OKAY);
        axi_rd(ssm_pkg::ADDR_CTRL, d, r);
        chk("ctrl kept", d, 32'h0);
        $display("test bus done");
        results();
    end
endmodule

bind ssm_core ssm_core_monitor u_mon (.*);
